// ### pkg/bmbl_pkg.sv
package bmbl_pkg;

	localparam int NMST = 3;
	localparam int NSLV = 4;
	localparam int NRG  = 7;
	localparam int CNT_W = 6;
	localparam int LE_NREG = 4;
	localparam int LE_IDX_W = 3;
	localparam int LE_DIV_W = 9;

	// master port numbers
	localparam logic [1:0] M_CODE = 2'h0;
	localparam logic [1:0] M_SYS  = 2'h1;
	localparam logic [1:0] M_DMA  = 2'h2;

	// slave port numbers
	localparam logic [1:0] S_SRAM  = 2'h0;
	localparam logic [1:0] S_XBUS  = 2'h1;
	localparam logic [1:0] S_FLASH = 2'h2;
	localparam logic [1:0] S_PER   = 2'h3;

	// address map
	localparam logic [3:0]  FLASH_TOP    = 4'h0;
	localparam logic [3:0]  SALIAS_TOP   = 4'h1;
	localparam logic [3:0]  XBUS_TOP     = 4'h8;
	localparam logic [31:0] SRAM_BASE    = 32'h2000_0000;
	localparam logic [31:0] SRAM_BB_BASE = 32'h2200_0000;
	localparam logic [31:0] PER_BASE     = 32'h4000_0000;
	localparam logic [31:0] PER_BB_BASE  = 32'h4200_0000;
	localparam logic [31:0] AES_LO       = 32'h400E_0000;
	localparam logic [31:0] AES_HI       = 32'h400E_03FF;
	localparam logic [31:0] LE_BASE      = 32'h4008_0000;
	localparam int          WIN_LSB      = 10;

	// region bits: flash, sram alias, sram, sram bb, ext bus, per, per bb
	localparam int RG_FLASH  = 0;
	localparam int RG_SALIAS = 1;
	localparam int RG_SRAM   = 2;
	localparam int RG_SBB    = 3;
	localparam int RG_XBUS   = 4;
	localparam int RG_PER    = 5;
	localparam int RG_PBB    = 6;
	localparam logic [NMST-1:0][NRG-1:0] MST_PERM =
		{7'h7D, 7'h7C, 7'h03};

	// wait cycles of a peripheral access
	localparam int BRIDGE_CYC = 2;
	localparam int SLAVE_CYC  = 1;

	// low-energy register window
	localparam logic [LE_IDX_W-1:0] LE_IDX_HOLD = 3'h4;
	localparam logic [LE_IDX_W-1:0] LE_IDX_PEND = 3'h5;
	localparam logic [LE_IDX_W-1:0] LE_IDX_STAT = 3'h6;
	localparam logic [1:0]          LE_SYNC_EDGES = 2'h3;
	localparam int CORE_HZ = 10_000_000;
	localparam int LE_HZ   = 32_768;
	localparam logic [LE_DIV_W-1:0] LE_DIV =
		LE_DIV_W'(CORE_HZ / LE_HZ);

	typedef enum logic [1:0] {M_IDLE, M_BUSY, M_BBWR} bmbl_mst_st_t;

	function automatic logic [NMST-1:0] bmbl_rr_pick(
		input logic [NMST-1:0] want,
		input logic [1:0]      last
	);
		logic [NMST-1:0] g;
		logic [1:0]      i;
		g = '0;
		i = last;
		for (int k = 0; k < NMST; k++) begin
			i = (i == 2'(NMST - 1)) ? 2'h0 : i + 2'h1;
			if (want[i] && (g == '0))
				g[i] = 1'h1;
		end
		return g;
	endfunction : bmbl_rr_pick

	function automatic logic [1:0] bmbl_oh_idx(input logic [NMST-1:0] oh);
		return oh[2] ? 2'h2 : (oh[1] ? 2'h1 : 2'h0);
	endfunction : bmbl_oh_idx

endpackage : bmbl_pkg

// ### pkg/bmbl_le_if.sv
interface bmbl_le_if
	import bmbl_pkg::*;
();
	logic                sel;
	logic                wr;
	logic [LE_IDX_W-1:0] idx;
	logic [31:0]         wdata;
	logic [31:0]         rdata;
	logic                take;

	modport mtx (output sel, output wr, output idx, output wdata,
		output take, input rdata);
	modport le (input sel, input wr, input idx, input wdata,
		input take, output rdata);
endinterface : bmbl_le_if

// ### rtl/bmbl_lesync.sv
module bmbl_lesync
	import bmbl_pkg::*;
(
	input  wire logic                      clk_in,
	input  wire logic                      rst_n_in,
	bmbl_le_if.le                          bus,
	input  wire logic [31:0]               le_stat_in,
	output logic      [LE_NREG-1:0][31:0]  le_regs_out
);
	logic [LE_DIV_W-1:0]      div_q;
	logic                     tick;
	logic                     hold_q;
	logic [LE_NREG-1:0]       pend_q;
	logic [LE_NREG-1:0][31:0] core_q;
	logic [LE_NREG-1:0][31:0] le_q;
	logic [31:0]              stat_q;
	logic                     wr_hit;

	// low-energy clock as an enable from the core clock
	assign tick   = (div_q == LE_DIV - 1'h1);
	assign wr_hit = bus.take & bus.sel & bus.wr;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_q  <= '0;
			hold_q <= 1'h0;
			stat_q <= '0;
		end else begin
			div_q <= tick ? '0 : div_q + 1'h1;
			if (wr_hit && bus.idx == LE_IDX_HOLD)
				hold_q <= bus.wdata[0];
			if (tick)
				stat_q <= le_stat_in; // [R20]
		end
	end

	for (genvar r = 0; r < LE_NREG; r++) begin : g_reg
		logic [1:0] edge_q;
		logic       wr_r;
		assign wr_r = wr_hit & (bus.idx == LE_IDX_W'(r));
		// runs on its own once started; no core handshake needed
		always_ff @(posedge clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				core_q[r] <= '0;
				le_q[r]   <= '0;
				pend_q[r] <= 1'h0;
				edge_q    <= 2'h0;
			end else if (wr_r) begin
				core_q[r] <= bus.wdata; // [R16]
				pend_q[r] <= 1'h1; // [R17]
				edge_q    <= 2'h0;
			end else if (pend_q[r] && !hold_q && tick) begin // [R22] [R23]
				if (edge_q == LE_SYNC_EDGES - 2'h1) begin // [R16] [R19]
					le_q[r]   <= core_q[r];
					pend_q[r] <= 1'h0; // [R17]
					edge_q    <= 2'h0;
				end else begin
					edge_q <= edge_q + 2'h1;
				end
			end
		end
	end

	// written value reads back at once; only pend_q tells completion
	assign bus.rdata =
		(bus.idx < LE_IDX_W'(LE_NREG)) ?
			core_q[bus.idx[1:0]] : // [R21]
		(bus.idx == LE_IDX_HOLD) ? {31'h0, hold_q} : // [R20]
		(bus.idx == LE_IDX_PEND) ? {{(32 - LE_NREG){1'h0}}, pend_q} :
		(bus.idx == LE_IDX_STAT) ? stat_q : 32'h0;

	assign le_regs_out = le_q;

endmodule : bmbl_lesync

// ### rtl/bmbl_matrix.sv
// Overview of operation
// R1: SRAM alias word at 0x22000000 maps to one SRAM bit by offset formula.
// R2: Peripheral alias at 0x42000000 maps to one peripheral bit likewise.
// R3: Alias reads are masked bit reads; alias writes are atomic bit updates.
// R4: Alias write takes bit 0 of data; alias read returns bit in bit 0.
// R5: No bit-band translation for the cipher block window.
// R6: Peripheral segment decodes into fixed 1 KB module windows.
// R7: Each master port reaches only its own set of slaves.
// R8: The code-space SRAM alias is refused to the DMA port.
// R9: Contending masters are granted in rotating order, no fixed priority.
// R10: Arbitration itself adds no wait states.
// R11: Each master may start a transfer every cycle; only slaves stall. Code masks req while ready_q is high, so at most every second cycle.
// R12: Multi-layer: masters reach different slaves at the same time.
// R13: Fast peripheral access costs 2 plus slave wait cycles.
// R14: Slow peripheral access wait is that sum times the clock ratio.
// R15: An ordinary peripheral register access counts one slave cycle.
// R16: Asynchronous register writes cross in three low-energy clock edges.
// R17: Pending flag sets on such a write and clears on completion.
// R18: Masters must not rewrite a register while its flag is pending.
// R19: Started synchronization finishes without the master waiting.
// R20: Low-energy-held registers read from that domain, others directly.
// R21: Readback may show new value early; only the flag means done.
// R22: While sync hold is set, writes are held back from crossing.
// R23: Clearing sync hold starts all held crossings together.
module bmbl_matrix
	import bmbl_pkg::*;
(
	input  wire logic                       clk_in,
	input  wire logic                       rst_n_in,
	input  wire logic [NMST-1:0]            mst_valid_in,
	input  wire logic [NMST-1:0][31:0]      mst_addr_in,
	input  wire logic [NMST-1:0]            mst_write_in,
	input  wire logic [NMST-1:0][31:0]      mst_wdata_in,
	output logic      [NMST-1:0]            mst_ready_out,
	output logic      [NMST-1:0][31:0]      mst_rdata_out,
	output logic      [NMST-1:0]            mst_err_out,
	output logic      [NSLV-1:0]            slv_sel_out,
	output logic      [NSLV-1:0][31:0]      slv_addr_out,
	output logic      [NSLV-1:0]            slv_write_out,
	output logic      [NSLV-1:0][31:0]      slv_wdata_out,
	input  wire logic [NSLV-1:0]            slv_ready_in,
	input  wire logic [NSLV-1:0][31:0]      slv_rdata_in,
	input  wire logic [3:0]                 per_ratio_in,
	output logic      [9:0]                 per_module_out,
	input  wire logic [31:0]                le_stat_in,
	output logic      [LE_NREG-1:0][31:0]   le_regs_out
);
	logic rst_s1_q;
	logic rst_s2_q;
	logic rst_n;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_s1_q <= 1'h0;
			rst_s2_q <= 1'h0;
		end else begin
			rst_s1_q <= 1'h1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// per-master decode and current transfer
	logic [NMST-1:0]            d_err;
	logic [NMST-1:0]            d_bb;
	logic [NMST-1:0][1:0]       d_tgt;
	logic [NMST-1:0][31:0]      d_addr;
	logic [NMST-1:0][4:0]       d_bit;
	logic [NMST-1:0]            req;
	logic [NMST-1:0]            hold;
	logic [NMST-1:0][1:0]       htgt;
	logic [NMST-1:0][1:0]       c_tgt;
	logic [NMST-1:0][31:0]      c_addr;
	logic [NMST-1:0]            c_wr;
	logic [NMST-1:0][31:0]      c_wd;
	logic [NMST-1:0]            gnt_m;
	// per-slave arbitration
	logic [NSLV-1:0][NMST-1:0]  gnt;
	logic [NSLV-1:0][NMST-1:0]  act;
	logic [NSLV-1:0]            e_rdy;
	logic [NSLV-1:0][31:0]      e_rdata;
	logic [NSLV-1:0][1:0]       a_idx;
	// peripheral wait count, ratio 0 taken as 1
	logic [3:0]                 ratio_eff;
	logic [CNT_W-1:0]           n_wait;
	logic                       le_hit;
	logic [NMST-1:0]            xfer_ok;

	bmbl_le_if le_bus ();

	assign ratio_eff = (per_ratio_in == 4'h0) ? 4'h1 : per_ratio_in;
	assign n_wait = CNT_W'((BRIDGE_CYC + SLAVE_CYC)
		* ratio_eff); // [R13] [R14] [R15]

	for (genvar m = 0; m < NMST; m++) begin : g_mst
		logic [31:0]     a;
		logic [24:0]     off;
		logic [19:0]     bb_word;
		logic [31:0]     pbb_tgt;
		logic            aes;
		logic [NRG-1:0]  rg;
		bmbl_mst_st_t    st_q;
		logic [1:0]      tgt_q;
		logic [31:0]     addr_q;
		logic [4:0]      bit_q;
		logic            bb_q;
		logic            wr_q;
		logic [31:0]     wdata_q;
		logic [CNT_W-1:0] cnt_q;
		logic            ready_q;
		logic            err_q;
		logic [31:0]     rdata_q;
		logic            c_bb;
		logic [4:0]      c_bit;
		logic            c_wro;
		logic [31:0]     c_wdo;
		logic            act_m;
		logic            bbw1;
		logic            done;
		logic            errhit;
		logic [31:0]     rd;
		logic [31:0]     mask;
		logic [31:0]     merged;

		assign a       = mst_addr_in[m];
		assign off     = a[24:0];
		assign bb_word = {off[24:7], 2'h0}; // [R1] [R2]
		assign pbb_tgt = PER_BASE | {12'h0, bb_word}; // [R2]
		assign aes     = (pbb_tgt >= AES_LO) && (pbb_tgt <= AES_HI);
		assign rg[RG_FLASH]  = (a[31:28] == FLASH_TOP);
		assign rg[RG_SALIAS] = (a[31:28] == SALIAS_TOP);
		assign rg[RG_SRAM]   = (a[31:20] == SRAM_BASE[31:20]);
		assign rg[RG_SBB]    = (a[31:25] == SRAM_BB_BASE[31:25]);
		assign rg[RG_XBUS]   = (a[31:28] == XBUS_TOP);
		assign rg[RG_PER]    = (a[31:20] == PER_BASE[31:20]);
		assign rg[RG_PBB]    = (a[31:25] == PER_BB_BASE[31:25]);

		// unmapped or not permitted answers with an error
		assign d_err[m] = ~|(rg & MST_PERM[m]) // [R7] [R8]
			| (rg[RG_PBB] & aes); // [R5]
		assign d_bb[m]  = rg[RG_SBB] | rg[RG_PBB]; // [R3]
		assign d_bit[m] = off[6:2]; // [R1]
		assign d_tgt[m] = rg[RG_FLASH] ? S_FLASH :
			rg[RG_XBUS] ? S_XBUS :
			(rg[RG_PER] | rg[RG_PBB]) ? S_PER : S_SRAM;
		assign d_addr[m] =
			rg[RG_SALIAS] ? {SRAM_BASE[31:28], a[27:0]} :
			rg[RG_SBB] ? (SRAM_BASE | {12'h0, bb_word}) : // [R1]
			rg[RG_PBB] ? pbb_tgt : a;

		// a held ready blocks re-issue of the same request
		assign req[m] = mst_valid_in[m] & ~ready_q & ~d_err[m]
			& (st_q == M_IDLE); // [R11]
		assign errhit = mst_valid_in[m] & ~ready_q & d_err[m]
			& (st_q == M_IDLE);
		assign hold[m] = (st_q != M_IDLE);
		assign htgt[m] = tgt_q;

		// first cycle is driven straight from the master's inputs
		assign c_tgt[m]  = hold[m] ? tgt_q : d_tgt[m];
		assign c_addr[m] = hold[m] ? addr_q : d_addr[m];
		assign c_bb      = hold[m] ? bb_q : d_bb[m];
		assign c_bit     = hold[m] ? bit_q : d_bit[m];
		assign c_wro     = hold[m] ? wr_q : mst_write_in[m];
		assign c_wdo     = hold[m] ? wdata_q : mst_wdata_in[m];
		assign c_wr[m]   = (st_q == M_BBWR) | (c_wro & ~c_bb); // [R3]
		assign c_wd[m]   = c_wdo;

		assign act_m = hold[m] | gnt_m[m];
		assign xfer_ok[m] = act_m & e_rdy[c_tgt[m]]
			& ((c_tgt[m] != S_PER) | (hold[m] & (cnt_q == '0)));
		assign bbw1 = xfer_ok[m] & c_bb & c_wro & (st_q != M_BBWR);
		assign done = xfer_ok[m] & ~bbw1;

		assign rd     = e_rdata[c_tgt[m]];
		assign mask   = 32'h1 << c_bit;
		assign merged = c_wdo[0] ? (rd | mask) : (rd & ~mask); // [R4]

		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n) begin
				st_q    <= M_IDLE;
				tgt_q   <= S_SRAM;
				addr_q  <= '0;
				bit_q   <= '0;
				bb_q    <= 1'h0;
				wr_q    <= 1'h0;
				wdata_q <= '0;
				cnt_q   <= '0;
			end else begin
				if (cnt_q != '0)
					cnt_q <= cnt_q - 1'h1;
				case (st_q)
				M_IDLE: begin
					if (gnt_m[m]) begin
						tgt_q   <= d_tgt[m];
						addr_q  <= d_addr[m];
						bit_q   <= d_bit[m];
						bb_q    <= d_bb[m];
						wr_q    <= mst_write_in[m];
						wdata_q <= mst_wdata_in[m];
						cnt_q   <= n_wait - 1'h1; // [R13] [R14]
						st_q    <= done ? M_IDLE : M_BUSY;
					end
				end
				M_BUSY: begin
					if (bbw1) begin
						// slave stays locked between read and write
						wdata_q <= merged; // [R3]
						cnt_q   <= n_wait - 1'h1;
						st_q    <= M_BBWR;
					end else if (done) begin
						st_q <= M_IDLE;
					end
				end
				M_BBWR: begin
					if (done)
						st_q <= M_IDLE;
				end
				default: st_q <= M_IDLE;
				endcase
				if (st_q == M_IDLE && bbw1) begin
					wdata_q <= merged;
					cnt_q   <= n_wait - 1'h1;
					st_q    <= M_BBWR;
				end
			end
		end

		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n) begin
				ready_q <= 1'h0;
				err_q   <= 1'h0;
				rdata_q <= '0;
			end else begin
				ready_q <= done | errhit;
				err_q   <= errhit;
				if (done)
					rdata_q <= c_bb ? {31'h0, rd[c_bit]} : rd; // [R4]
			end
		end

		assign mst_ready_out[m] = ready_q;
		assign mst_err_out[m]   = err_q;
		assign mst_rdata_out[m] = rdata_q;
	end

	for (genvar s = 0; s < NSLV; s++) begin : g_slv
		logic [NMST-1:0] own;
		logic [NMST-1:0] want;
		logic [1:0]      last_q;

		for (genvar m = 0; m < NMST; m++) begin : g_w
			assign own[m]  = hold[m] & (htgt[m] == 2'(s));
			assign want[m] = req[m] & (d_tgt[m] == 2'(s)); // [R12]
		end
		// grant in the request cycle; owner keeps the slave
		assign gnt[s] = (|own) ? '0 : bmbl_rr_pick(want, last_q); // [R9] [R10]
		assign act[s] = own | gnt[s];
		assign a_idx[s] = bmbl_oh_idx(act[s]);

		always_ff @(posedge clk_in or negedge rst_n) begin
			if (!rst_n)
				last_q <= M_DMA;
			else if (|gnt[s])
				last_q <= bmbl_oh_idx(gnt[s]); // [R9]
		end

		assign slv_addr_out[s]  = c_addr[a_idx[s]];
		assign slv_write_out[s] = c_wr[a_idx[s]] & (|act[s]);
		assign slv_wdata_out[s] = c_wd[a_idx[s]];
	end

	for (genvar m = 0; m < NMST; m++) begin : g_gm
		assign gnt_m[m] = gnt[d_tgt[m]][m];
	end

	// low-energy window is served locally, not by the external port
	assign le_hit = (slv_addr_out[S_PER][31:WIN_LSB]
		== LE_BASE[31:WIN_LSB]);
	assign slv_sel_out[S_SRAM]  = |act[S_SRAM];
	assign slv_sel_out[S_XBUS]  = |act[S_XBUS];
	assign slv_sel_out[S_FLASH] = |act[S_FLASH];
	assign slv_sel_out[S_PER]   = (|act[S_PER]) & ~le_hit;
	assign per_module_out = slv_addr_out[S_PER][19:WIN_LSB]; // [R6]

	assign e_rdy[S_SRAM]    = slv_ready_in[S_SRAM];
	assign e_rdy[S_XBUS]    = slv_ready_in[S_XBUS];
	assign e_rdy[S_FLASH]   = slv_ready_in[S_FLASH];
	assign e_rdy[S_PER]     = le_hit | slv_ready_in[S_PER];
	assign e_rdata[S_SRAM]  = slv_rdata_in[S_SRAM];
	assign e_rdata[S_XBUS]  = slv_rdata_in[S_XBUS];
	assign e_rdata[S_FLASH] = slv_rdata_in[S_FLASH];
	assign e_rdata[S_PER]   = le_hit ? le_bus.rdata : // [R20]
		slv_rdata_in[S_PER];

	assign le_bus.sel   = (|act[S_PER]) & le_hit;
	assign le_bus.wr    = slv_write_out[S_PER];
	assign le_bus.idx   = slv_addr_out[S_PER][LE_IDX_W+1:2];
	assign le_bus.wdata = slv_wdata_out[S_PER];
	assign le_bus.take  = xfer_ok[a_idx[S_PER]];

	bmbl_lesync u_lesync (
		.clk_in      (clk_in),
		.rst_n_in    (rst_n),
		.bus         (le_bus.le),
		.le_stat_in  (le_stat_in),
		.le_regs_out (le_regs_out)
	);

endmodule : bmbl_matrix

// ### tb/bmbl_slv_model.sv
module bmbl_slv_model
	import bmbl_pkg::*;
(
	input  wire logic                  clk_in,
	input  wire logic [NSLV-1:0]       sel_in,
	input  wire logic [NSLV-1:0][31:0] addr_in,
	input  wire logic [NSLV-1:0]       write_in,
	input  wire logic [NSLV-1:0][31:0] wdata_in,
	input  wire logic [NSLV-1:0]       stall_in,
	output logic      [NSLV-1:0]       ready_out,
	output logic      [NSLV-1:0][31:0] rdata_out
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [31:0]           mem_q [NSLV][64];
	logic [NSLV-1:0][31:0] last_q;

	initial begin
		for (int s = 0; s < NSLV; s++) begin
			for (int i = 0; i < 64; i++) begin
				mem_q[s][i] = 32'h0;
			end
		end
		last_q = '0;
	end

	// unselected data lines show the inverse of the last word, never a copy
	always_comb begin
		for (int s = 0; s < NSLV; s++) begin
			ready_out[s] = sel_in[s] & ~stall_in[s];
			rdata_out[s] = sel_in[s] ? mem_q[s][addr_in[s][7:2]]
				: ~last_q[s];
		end
	end

	always @(posedge clk_in) begin
		for (int s = 0; s < NSLV; s++) begin
			if (ready_out[s] && write_in[s]) begin
				mem_q[s][addr_in[s][7:2]] <= wdata_in[s];
			end
			if (sel_in[s]) begin
				last_q[s] <= rdata_out[s];
			end
		end
	end
endmodule : bmbl_slv_model

// ### tb/bmbl_matrix_chk.sv
module bmbl_matrix_chk
	import bmbl_pkg::*;
(
	input wire logic                  clk_in,
	input wire logic                  rst_n_in,
	input wire logic [NMST-1:0]       mst_valid_in,
	input wire logic [NMST-1:0][31:0] mst_addr_in,
	input wire logic [NMST-1:0]       mst_write_in,
	input wire logic [NMST-1:0][31:0] mst_wdata_in,
	input wire logic [NMST-1:0]       mst_ready_out,
	input wire logic [NMST-1:0]       mst_err_out,
	input wire logic [NSLV-1:0]       slv_sel_out,
	input wire logic [NSLV-1:0][31:0] slv_addr_out,
	input wire logic [NSLV-1:0]       slv_write_out,
	input wire logic [NSLV-1:0][31:0] slv_wdata_out,
	input wire logic [NSLV-1:0]       slv_ready_in,
	input wire logic [NSLV-1:0][31:0] slv_rdata_in,
	input wire logic [3:0]            per_ratio_in,
	input wire logic [9:0]            per_module_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	logic [31:0] bb_tgt;
	logic [31:0] bb_bit;
	assign bb_tgt = SRAM_BASE | {12'h0, mst_addr_in[M_SYS][24:7], 2'h0};
	assign bb_bit = 32'h1 << mst_addr_in[M_SYS][6:2];

	sequence s_bb_rd;
		slv_sel_out[S_SRAM] && slv_ready_in[S_SRAM] && !slv_write_out[S_SRAM]
		&& mst_valid_in[M_SYS] && mst_write_in[M_SYS]
		&& mst_addr_in[M_SYS][31:25] == 7'h11
		&& slv_addr_out[S_SRAM] == bb_tgt;
	endsequence
	// the merge must use the word read one cycle earlier, not a fresh one
	sequence s_bb_wr;
		slv_sel_out[S_SRAM] && slv_write_out[S_SRAM]
		&& slv_addr_out[S_SRAM] == $past(slv_addr_out[S_SRAM])
		&& slv_wdata_out[S_SRAM] == (($past(slv_rdata_in[S_SRAM]) & ~bb_bit)
		| (mst_wdata_in[M_SYS][0] ? bb_bit : 32'h0));
	endsequence

	AST_BB_WRITE: assert property (
		s_bb_rd |=> s_bb_wr ##1 mst_ready_out[M_SYS])
		else $error("bit-band write not a merged read-modify-write");
	AST_ERR_READY: assert property (
		(mst_err_out & ~mst_ready_out) == '0)
		else $error("error flag without ready");
	AST_RDY_PULSE: assert property (
		mst_ready_out != '0 |=> (mst_ready_out & $past(mst_ready_out)) == '0)
		else $error("ready longer than one cycle");
	AST_RDY_CAUSE: assert property (
		($past(mst_valid_in) & mst_ready_out) == mst_ready_out)
		else $error("ready without a request");
	AST_NO_WAIT: assert property (
		(slv_sel_out[S_FLASH] && slv_ready_in[S_FLASH])
		|| (slv_sel_out[S_XBUS] && slv_ready_in[S_XBUS])
		|=> mst_ready_out != '0)
		else $error("wait state added to memory access");
	AST_DMA_ALIAS: assert property (
		mst_valid_in[M_DMA] && mst_addr_in[M_DMA][31:28] == 4'h1
		&& !mst_ready_out[M_DMA]
		|=> mst_ready_out[M_DMA] && mst_err_out[M_DMA])
		else $error("dma reached code-space sram");
	AST_PER_FAST: assert property (
		$rose(slv_sel_out[S_PER]) && per_ratio_in < 4'h2
		|-> slv_sel_out[S_PER] [*4])
		else $error("fast peripheral access too short");
	AST_PER_SLOW: assert property (
		$rose(slv_sel_out[S_PER]) && per_ratio_in == 4'h2
		|-> slv_sel_out[S_PER] [*7])
		else $error("slow peripheral access too short");
	AST_PER_MODULE: assert property (
		slv_sel_out[S_PER] |-> per_module_out == slv_addr_out[S_PER][19:10])
		else $error("peripheral window index wrong");
endmodule : bmbl_matrix_chk

bind bmbl_matrix bmbl_matrix_chk u_chk (.clk_in, .rst_n_in, .mst_valid_in,
	.mst_addr_in, .mst_write_in, .mst_wdata_in, .mst_ready_out,
	.mst_err_out, .slv_sel_out, .slv_addr_out, .slv_write_out,
	.slv_wdata_out, .slv_ready_in, .slv_rdata_in, .per_ratio_in,
	.per_module_out);

// ### tb/bmbl_matrix_test.sv
module bmbl_matrix_test
	import bmbl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [31:0] LE_A = 32'h4008_0000;
	// master, error expected, address
	localparam logic [34:0] MAP_T [7] = '{
		{M_DMA, 1'h1, 32'h1000_0010}, {M_CODE, 1'h1, 32'h2000_0010},
		{M_SYS, 1'h1, 32'h0000_0100}, {M_SYS, 1'h1, 32'h9000_0000},
		{M_DMA, 1'h0, 32'h0000_0100}, {M_DMA, 1'h0, 32'h8000_0000},
		{M_CODE, 1'h0, 32'h0000_0100}};

	logic                     clk_in;
	logic                     rst_n_in;
	logic [NMST-1:0]          mst_valid_in;
	logic [NMST-1:0][31:0]    mst_addr_in;
	logic [NMST-1:0]          mst_write_in;
	logic [NMST-1:0][31:0]    mst_wdata_in;
	logic [NMST-1:0]          mst_ready_out;
	logic [NMST-1:0][31:0]    mst_rdata_out;
	logic [NMST-1:0]          mst_err_out;
	logic [NSLV-1:0]          slv_sel_out;
	logic [NSLV-1:0][31:0]    slv_addr_out;
	logic [NSLV-1:0]          slv_write_out;
	logic [NSLV-1:0][31:0]    slv_wdata_out;
	logic [NSLV-1:0]          slv_ready_in;
	logic [NSLV-1:0][31:0]    slv_rdata_in;
	logic [NSLV-1:0]          slv_stall;
	logic [3:0]               per_ratio_in;
	logic [9:0]               per_module_out;
	logic [31:0]              le_stat_in;
	logic [LE_NREG-1:0][31:0] le_regs_out;
	logic [NMST-1:0][31:0]    rd_v;
	logic [NMST-1:0]          err_v;
	int                       lat_v [NMST];
	longint                   tm_v [NMST];
	int                       err_total;
	int                       n_compared;
	int                       lapse;
	longint                   t0;

	bmbl_matrix u_dut (.clk_in, .rst_n_in, .mst_valid_in, .mst_addr_in,
		.mst_write_in, .mst_wdata_in, .mst_ready_out, .mst_rdata_out,
		.mst_err_out, .slv_sel_out, .slv_addr_out, .slv_write_out,
		.slv_wdata_out, .slv_ready_in, .slv_rdata_in, .per_ratio_in,
		.per_module_out, .le_stat_in, .le_regs_out);
	bmbl_slv_model u_slv (.clk_in, .sel_in(slv_sel_out),
		.addr_in(slv_addr_out), .write_in(slv_write_out),
		.wdata_in(slv_wdata_out), .stall_in(slv_stall),
		.ready_out(slv_ready_in), .rdata_out(slv_rdata_in));

	always #50 clk_in = ~clk_in;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic end_of_test();
		$display("mismatches=%0d compares=%0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	// request held until ready is seen; latency counted in edges
	task automatic bus(input logic [1:0] m, input logic [31:0] a,
		input logic w, input logic [31:0] d);
		lat_v[m] = 0;
		@(posedge clk_in);
		mst_valid_in[m] <= 1'h1;
		mst_addr_in[m]  <= a;
		mst_write_in[m] <= w;
		mst_wdata_in[m] <= d;
		do begin
			@(posedge clk_in);
			#1;
			lat_v[m]++;
		end while (mst_ready_out[m] !== 1'h1 && lat_v[m] < 2000);
		if (mst_ready_out[m] !== 1'h1) begin
			err_total++;
		end
		rd_v[m]  = mst_rdata_out[m];
		err_v[m] = mst_err_out[m];
		tm_v[m]  = $time;
		@(posedge clk_in);
		mst_valid_in[m] <= 1'h0;
	endtask : bus

	task automatic t_map();
		for (int i = 0; i < 7; i++) begin
			bus(MAP_T[i][34:33], MAP_T[i][31:0], 1'h0, 32'h0);
			check({31'h0, err_v[MAP_T[i][34:33]]}, {31'h0, MAP_T[i][32]});
		end
		bus(M_SYS, 32'h2000_0010, 1'h1, 32'hA5A5_0001);
		check(32'(lat_v[M_SYS]), 32'h1);
		bus(M_CODE, 32'h1000_0010, 1'h0, 32'h0);
		check(rd_v[M_CODE], 32'hA5A5_0001);
	endtask : t_map

	task automatic t_bb();
		bus(M_SYS, 32'h2000_0020, 1'h1, 32'hF0F0_0000);
		bus(M_SYS, 32'h2200_040C, 1'h1, 32'h0000_0001);
		check(32'(lat_v[M_SYS]), 32'h2);
		bus(M_SYS, 32'h2200_047C, 1'h1, 32'hFFFF_FFFE);
		bus(M_SYS, 32'h2000_0020, 1'h0, 32'h0);
		check(rd_v[M_SYS], 32'h70F0_0008);
		bus(M_SYS, 32'h2200_0450, 1'h0, 32'h0);
		check(rd_v[M_SYS], 32'h1);
		bus(M_SYS, 32'h2200_0440, 1'h0, 32'h0);
		check(rd_v[M_SYS], 32'h0);
		bus(M_SYS, 32'h4200_0114, 1'h1, 32'h1);
		bus(M_SYS, 32'h4000_0008, 1'h0, 32'h0);
		check(rd_v[M_SYS], 32'h20);
		bus(M_SYS, 32'h43C0_0000, 1'h1, 32'h1);
		check({31'h0, err_v[M_SYS]}, 32'h1);
		bus(M_SYS, 32'h400E_0004, 1'h0, 32'h0);
		check({31'h0, err_v[M_SYS]}, 32'h0);
	endtask : t_bb

	task automatic t_wait();
		fork
			bus(M_SYS, 32'h4000_1000, 1'h0, 32'h0);
			begin
				repeat (2) @(posedge clk_in);
				#1;
				check({22'h0, per_module_out}, 32'h4);
			end
		join
		check(32'(lat_v[M_SYS]), 32'h4);
		per_ratio_in <= 4'h2;
		bus(M_DMA, 32'h4001_0000, 1'h0, 32'h0);
		check(32'(lat_v[M_DMA]), 32'h7);
		per_ratio_in <= 4'h0;
		bus(M_SYS, 32'h4000_1000, 1'h0, 32'h0);
		check(32'(lat_v[M_SYS]), 32'h4);
		per_ratio_in <= 4'h1;
	endtask : t_wait

	task automatic t_ml();
		fork
			bus(M_DMA, 32'h8000_0008, 1'h0, 32'h0);
			bus(M_CODE, 32'h0000_0004, 1'h0, 32'h0);
			begin
				@(posedge clk_in);
				slv_stall[S_XBUS] <= 1'h1;
				repeat (3) @(posedge clk_in);
				slv_stall[S_XBUS] <= 1'h0;
			end
		join
		check(32'(lat_v[M_DMA]), 32'h4);
		check(32'(lat_v[M_CODE]), 32'h1);
	endtask : t_ml

	task automatic t_rr();
		int f [2];
		for (int r = 0; r < 2; r++) begin
			fork
				bus(M_CODE, 32'h1000_0030, 1'h0, 32'h0);
				bus(M_SYS, 32'h2000_0034, 1'h0, 32'h0);
				bus(M_DMA, 32'h2000_0038, 1'h0, 32'h0);
			join
			f[r] = (tm_v[0] < tm_v[1]) ? ((tm_v[0] < tm_v[2]) ? 0 : 2)
				: ((tm_v[1] < tm_v[2]) ? 1 : 2);
			check(32'(tm_v[(f[r] + 1) % 3] < tm_v[(f[r] + 2) % 3]), 32'h1);
		end
		check(32'(f[1]), 32'(f[0]));
	endtask : t_rr

	task automatic wait_idle();
		for (int i = 0; i < 500; i++) begin
			bus(M_SYS, LE_A + 32'h14, 1'h0, 32'h0);
			if (rd_v[M_SYS][3:0] === 4'h0) begin
				break;
			end
		end
		lapse = int'(($time - t0) / 100);
	endtask : wait_idle

	task automatic t_le();
		t0 = $time;
		bus(M_SYS, LE_A, 1'h1, 32'h1234_5678);
		check(32'(lat_v[M_SYS] < 8), 32'h1);
		bus(M_SYS, LE_A, 1'h0, 32'h0);
		check(rd_v[M_SYS], 32'h1234_5678);
		check(le_regs_out[0], 32'h0);
		bus(M_SYS, LE_A + 32'h14, 1'h0, 32'h0);
		check(rd_v[M_SYS], 32'h1);
		wait_idle();
		check(le_regs_out[0], 32'h1234_5678);
		check(32'(lapse >= 2 * int'(LE_DIV)), 32'h1);
		check(32'(lapse <= 3 * int'(LE_DIV) + 40), 32'h1);
		bus(M_SYS, LE_A + 32'h10, 1'h1, 32'h1);
		bus(M_SYS, LE_A, 1'h1, 32'h0000_00FF);
		bus(M_SYS, LE_A + 32'h8, 1'h1, 32'hAAAA_0002);
		repeat (1000) @(posedge clk_in);
		bus(M_SYS, LE_A + 32'h14, 1'h0, 32'h0);
		check(rd_v[M_SYS], 32'h5);
		check(le_regs_out[2], 32'h0);
		t0 = $time;
		bus(M_SYS, LE_A + 32'h10, 1'h1, 32'h0);
		wait_idle();
		check(le_regs_out[0], 32'h0000_00FF);
		check(le_regs_out[2], 32'hAAAA_0002);
		check(32'(lapse <= 3 * int'(LE_DIV) + 40), 32'h1);
		bus(M_SYS, LE_A + 32'h18, 1'h0, 32'h0);
		check(rd_v[M_SYS], le_stat_in);
		bus(M_SYS, LE_A + 32'h10, 1'h0, 32'h0);
		check(rd_v[M_SYS], 32'h0);
	endtask : t_le

	initial begin
		repeat (20000) @(posedge clk_in);
		err_total++;
		end_of_test();
	end

	initial begin
		clk_in = 1'h0;
		rst_n_in = 1'h0;
		mst_valid_in = '0;
		mst_addr_in = '0;
		mst_write_in = '0;
		mst_wdata_in = '0;
		slv_stall = '0;
		per_ratio_in = 4'h1;
		le_stat_in = 32'hC0DE_0006;
		err_total = 0;
		n_compared = 0;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'h1;
		repeat (3) @(posedge clk_in);
		t_map();
		t_bb();
		t_wait();
		t_ml();
		t_rr();
		t_le();
		end_of_test();
	end
endmodule : bmbl_matrix_test
